//--- indsp_pkg.sv
`default_nettype none
package indsp_pkg;

  // Serial word and field sizes, and prescaler counter width
  localparam int unsigned PRIM_W = 20;
  localparam int unsigned ENH_W  = 8;
  localparam int unsigned MAIN_W = 9;
  localparam int unsigned REF_W  = 6;
  localparam int unsigned SWL_W  = 4;
  localparam int unsigned PSC_W  = 4;

  // Divider setting word layout (first-in bit lands on the top)
  localparam int unsigned PRIM_REF_HI_MSB  = 19;
  localparam int unsigned PRIM_REF_HI_LSB  = 18;
  localparam int unsigned PRIM_MAIN_HI_MSB = 17;
  localparam int unsigned PRIM_MAIN_HI_LSB = 16;
  localparam int unsigned PRIM_PRE_EN      = 15;
  localparam int unsigned PRIM_MAIN_LO_MSB = 14;
  localparam int unsigned PRIM_MAIN_LO_LSB = 8;
  localparam int unsigned PRIM_REF_LO_MSB  = 7;
  localparam int unsigned PRIM_REF_LO_LSB  = 4;
  localparam int unsigned PRIM_SWL_MSB     = 3;
  localparam int unsigned PRIM_SWL_LSB     = 0;

  // Extra control word layout
  localparam int unsigned ENH_FP_OUT   = 5;
  localparam int unsigned ENH_PWR_DN   = 4;
  localparam int unsigned ENH_CNT_LOAD = 3;
  localparam int unsigned ENH_MODULUS_SELECT_OUT = 2;
  localparam int unsigned ENH_FC_OUT   = 1;

  // Reset values of the serial registers
  localparam logic [PRIM_W-1:0] PRIM_RST = 20'h00000;
  localparam logic [ENH_W-1:0]  ENH_RST  = 8'h00;

  // Prescaler moduli, as terminal counts (modulus minus one)
  localparam logic [PSC_W-1:0] PSC_TC_LOW  = 4'h9;
  localparam logic [PSC_W-1:0] PSC_TC_HIGH = 4'ha;

endpackage : indsp_pkg

`default_nettype wire

//--- indsp_core.sv
`timescale 1ns/1ns
`default_nettype none

// Contract
// - prescaler divides by ten or eleven
// - prescaler, modulus logic, nine-bit main counter
// - enable bit low uses prescaler, high bypasses
// - ratio ten times (M+1) plus A
// - main setting one divides by two
// - bypassed chain divides by M plus one
// - six-bit reference divides by R plus one
// - reference setting zero passes straight through
// - twenty bits shift MSB first when strobes low
// - write strobe rise copies into secondary
// - bank select high primary, low secondary
// - extra word shifts eight bits, MSB first
// - extra word captured on its strobe fall
// - extra bits act only while enable low
// - setting word field order as documented
// - extra word field order as documented
// - swallow counter drives the modulus select
// - detector gives separate up and down
// - chosen divider signal routed to output pin
// - reserved zero, power down, continuous load
// - rising edges; leading side pulses low
// - filter is NAND, lock is AND
module indsp_core
  import indsp_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic rf_in,
  input  wire logic ref_in,
  input  wire logic sclk,
  input  wire logic sdata,
  input  wire logic serial_write,
  input  wire logic extra_write,
  input  wire logic extra_enable_n,
  input  wire logic bank_select,
  output logic      pump_up_n,
  output logic      pump_down_n,
  output logic      lock_filter,
  output logic      lock_indicator_o,
  output logic      lock_indicator_oe,
  output logic      divider_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: every pin is asynchronous to ref_clk
  localparam int unsigned NSYNC = 8;
  // Reset to the pins' idle levels so no false strobe edge follows reset
  localparam logic [NSYNC-1:0] SYNC_IDLE = 8'h0a;

  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] meta_q;
  logic [NSYNC-1:0] sync_q;
  logic [NSYNC-1:0] sync_prev_q;

  assign pin_raw = {rf_in, ref_in, sclk, sdata, serial_write, extra_write,
                    extra_enable_n, bank_select};

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      meta_q      <= SYNC_IDLE;
      sync_q      <= SYNC_IDLE;
      sync_prev_q <= SYNC_IDLE;
    end else begin
      meta_q      <= pin_raw;
      sync_q      <= meta_q;
      sync_prev_q <= sync_q;
    end
  end

  logic rf_s, ref_s, sclk_s, sdata_s, swr_s, ewr_s, enh_n_s, bank_s;
  assign {rf_s, ref_s, sclk_s, sdata_s, swr_s, ewr_s, enh_n_s, bank_s} = sync_q;

  logic rf_rise, ref_rise, sclk_rise, swr_rise, ewr_fall;
  assign rf_rise   = rf_s & ~sync_prev_q[7];
  assign ref_rise  = ref_s & ~sync_prev_q[6];
  assign sclk_rise = sclk_s & ~sync_prev_q[5];
  assign swr_rise  = swr_s & ~sync_prev_q[3];
  assign ewr_fall  = ~ewr_s & sync_prev_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // Serial port
  logic [PRIM_W-1:0] prim_q;
  logic [PRIM_W-1:0] sec_q;
  logic [ENH_W-1:0]  enh_sh_q;
  logic [ENH_W-1:0]  enh_hold_q;

  // Shifting relies on the strobes standing still around sclk edges
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      prim_q <= PRIM_RST;
    end else if (sclk_rise && !swr_s && !ewr_s) begin
      prim_q <= {prim_q[PRIM_W-2:0], sdata_s};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      enh_sh_q <= ENH_RST;
    end else if (sclk_rise && !swr_s && ewr_s) begin
      enh_sh_q <= {enh_sh_q[ENH_W-2:0], sdata_s};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sec_q <= PRIM_RST;
    end else if (swr_rise) begin
      sec_q <= prim_q;
    end
  end

  // Double buffer keeps live control bits still during a shift
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      enh_hold_q <= ENH_RST;
    end else if (ewr_fall) begin
      enh_hold_q <= enh_sh_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Settings decode
  logic [PRIM_W-1:0] sel_word;
  logic [ENH_W-1:0]  enh_act;
  logic [MAIN_W-1:0] m_set;
  logic [REF_W-1:0]  r_set;
  logic [SWL_W-1:0]  a_set;
  logic              pre_bypass;
  logic              pwr_dn;
  logic              cnt_load;

  assign sel_word = bank_s ? prim_q : sec_q;
  // Reserved bits are ignored; the controller writes them as zero
  assign enh_act  = enh_n_s ? ENH_RST : enh_hold_q;

  assign m_set = {sel_word[PRIM_MAIN_HI_MSB:PRIM_MAIN_HI_LSB],
                  sel_word[PRIM_MAIN_LO_MSB:PRIM_MAIN_LO_LSB]};
  assign r_set = {sel_word[PRIM_REF_HI_MSB:PRIM_REF_HI_LSB],
                  sel_word[PRIM_REF_LO_MSB:PRIM_REF_LO_LSB]};
  assign a_set      = sel_word[PRIM_SWL_MSB:PRIM_SWL_LSB];
  assign pre_bypass = sel_word[PRIM_PRE_EN];
  assign pwr_dn     = enh_act[ENH_PWR_DN];
  assign cnt_load   = enh_act[ENH_CNT_LOAD];

  // A setting change reloads at once only while counter load is set
  logic [PRIM_W-1:0] sel_prev_q;
  logic              reload_now;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sel_prev_q <= PRIM_RST;
    end else begin
      sel_prev_q <= sel_word;
    end
  end

  assign reload_now = cnt_load && (sel_word != sel_prev_q);

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler
  logic [PSC_W-1:0] psc_q;
  logic             modulus_select;
  logic             psc_tick;
  logic [PSC_W-1:0] psc_tc;

  assign psc_tc   = modulus_select ? PSC_TC_HIGH : PSC_TC_LOW;
  assign psc_tick = rf_rise && !pwr_dn && (pre_bypass || psc_q == psc_tc);

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      psc_q <= '0;
    end else if (pwr_dn || pre_bypass || reload_now) begin
      psc_q <= '0;
    end else if (rf_rise) begin
      psc_q <= (psc_q == psc_tc) ? '0 : psc_q + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main and swallow counters
  logic [MAIN_W-1:0] main_q;
  logic [SWL_W-1:0]  swl_q;
  logic              fp_evt;
  logic              fp_q;

  assign modulus_select   = !pre_bypass && (swl_q != '0);
  assign fp_evt = psc_tick && (main_q == '0);

  // M+1 prescaler cycles a period, the first A of them at eleven
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      main_q <= '0;
      swl_q  <= '0;
    end else if (pwr_dn || reload_now) begin
      main_q <= m_set;
      swl_q  <= a_set;
    end else if (fp_evt) begin
      main_q <= m_set;
      swl_q  <= a_set;
    end else if (psc_tick) begin
      main_q <= main_q - 9'h001;
      if (swl_q != '0) begin
        swl_q <= swl_q - 4'h1;
      end
    end
  end

  // Divided RF level: high for one prescaler cycle each period
  always_ff @(posedge ref_clk) begin
    if (!rst_b || pwr_dn) begin
      fp_q <= 1'b0;
    end else if (psc_tick) begin
      fp_q <= fp_evt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference counter
  logic [REF_W-1:0] ref_q;
  logic             fc_evt;
  logic             fc_q;
  logic             fc_level;

  assign fc_evt   = ref_rise && !pwr_dn && (ref_q == '0 || r_set == '0);
  assign fc_level = (r_set == '0) ? ref_s : fc_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ref_q <= '0;
    end else if (pwr_dn || reload_now || fc_evt) begin
      ref_q <= r_set;
    end else if (ref_rise) begin
      ref_q <= ref_q - 6'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b || pwr_dn) begin
      fc_q <= 1'b0;
    end else if (ref_rise) begin
      fc_q <= fc_evt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase-frequency detector: both set means both clear
  logic up_q;
  logic dn_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_b || pwr_dn) begin
      up_q <= 1'b0;
      dn_q <= 1'b0;
    end else if ((up_q || fc_evt) && (dn_q || fp_evt)) begin
      up_q <= 1'b0;
      dn_q <= 1'b0;
    end else begin
      up_q <= up_q || fc_evt;
      dn_q <= dn_q || fp_evt;
    end
  end

  assign pump_up_n   = ~up_q;
  assign pump_down_n = ~dn_q;

  // Open drain: pulls low whenever either pump pulse is active
  assign lock_filter       = ~(pump_up_n & pump_down_n);
  assign lock_indicator_o  = 1'b0;
  assign lock_indicator_oe = ~(pump_up_n & pump_down_n);

  ////////////////////////////////////////////////////////////////////////////
  // Shared divider output
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      divider_out <= 1'b0;
    end else if (enh_act[ENH_FP_OUT]) begin
      divider_out <= fp_q;
    end else if (enh_act[ENH_MODULUS_SELECT_OUT]) begin
      divider_out <= modulus_select;
    end else if (enh_act[ENH_FC_OUT]) begin
      divider_out <= fc_level;
    end else begin
      divider_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_prim_shift;
    sclk_rise && !swr_s && !ewr_s;
  endsequence

  property p_prim_shift;
    @(posedge ref_clk) disable iff (!rst_b)
      s_prim_shift |=> prim_q == {$past(prim_q[PRIM_W-2:0]), $past(sdata_s)};
  endproperty
  a_prim_shift: assert property (p_prim_shift) else $error("primary shift wrong");

  property p_enh_shift;
    @(posedge ref_clk) disable iff (!rst_b)
      sclk_rise && !swr_s && ewr_s |=> enh_sh_q == {$past(enh_sh_q[ENH_W-2:0]), $past(sdata_s)}
      && prim_q == $past(prim_q);
  endproperty
  a_enh_shift: assert property (p_enh_shift) else $error("extra shift wrong");

  property p_secondary;
    @(posedge ref_clk) disable iff (!rst_b)
      swr_rise |=> sec_q == $past(prim_q);
  endproperty
  a_secondary: assert property (p_secondary) else $error("secondary not copied");

  property p_hold;
    @(posedge ref_clk) disable iff (!rst_b)
      !ewr_fall ##1 !ewr_fall |-> $stable(enh_hold_q);
  endproperty
  a_hold: assert property (p_hold) else $error("hold changed without strobe fall");

  property p_reload;
    @(posedge ref_clk) disable iff (!rst_b)
      fp_evt && !pwr_dn && !reload_now |=> main_q == $past(m_set) && swl_q == $past(a_set);
  endproperty
  a_reload: assert property (p_reload) else $error("main reload wrong");

  property p_bypass_tick;
    @(posedge ref_clk) disable iff (!rst_b)
      pre_bypass && rf_rise && !pwr_dn |-> psc_tick && !modulus_select;
  endproperty
  a_bypass_tick: assert property (p_bypass_tick) else $error("bypass tick missing");

  property p_ref_zero;
    @(posedge ref_clk) disable iff (!rst_b)
      r_set == '0 && $past(r_set) == '0 && ref_rise && !pwr_dn |-> fc_evt;
  endproperty
  a_ref_zero: assert property (p_ref_zero) else $error("reference zero not passed");

  property p_up_pulse;
    @(posedge ref_clk) disable iff (!rst_b)
      fc_evt && !fp_evt && !dn_q && !pwr_dn |=> !pump_up_n && pump_down_n;
  endproperty
  a_up_pulse: assert property (p_up_pulse) else $error("up pulse missing");

  property p_no_both;
    @(posedge ref_clk) disable iff (!rst_b)
      !(up_q && dn_q);
  endproperty
  a_no_both: assert property (p_no_both) else $error("both pumps active");

  property p_power_down;
    @(posedge ref_clk) disable iff (!rst_b)
      pwr_dn |=> pump_up_n && pump_down_n && !lock_indicator_oe;
  endproperty
  a_power_down: assert property (p_power_down) else $error("pumps active in power down");

endmodule : indsp_core

`default_nettype wire

//--- indsp_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
// Stands in for the external controller on the four-wire programming port
module indsp_ctrl_model (
  input  wire logic ref_clk,
  output logic      sclk,
  output logic      sdata,
  output logic      serial_write,
  output logic      extra_write
);
  initial begin
    sclk         = 1'b0;
    sdata        = 1'b0;
    serial_write = 1'b1;
    extra_write  = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  // Serial clock idles low between frames; 80 ns period, 40 ns high
  task automatic send_bit(input logic b);
    sdata <= b;
    tick(5);
    sclk <= 1'b1;
    tick(10);
    sclk <= 1'b0;
    tick(3);
    // Hold time is over, so the line no longer shows the bit
    sdata <= ~b;
    tick(2);
  endtask : send_bit
  // Strobes stay steady for the whole frame
  task automatic write_setting(input logic [19:0] w, input logic latch);
    serial_write <= 1'b0;
    extra_write  <= 1'b0;
    tick(10);
    for (int i = 19; i >= 0; i--) send_bit(w[i]);
    tick(10);
    if (latch) serial_write <= 1'b1;
    tick(10);
  endtask : write_setting
  task automatic write_extra(input logic [7:0] e);
    extra_write  <= 1'b1;
    serial_write <= 1'b0;
    tick(10);
    for (int i = 7; i >= 0; i--) send_bit(e[i]);
    tick(10);
    extra_write <= 1'b0;
    tick(10);
  endtask : write_extra
endmodule : indsp_ctrl_model
`default_nettype wire

//--- indsp_core_bench.sv
`timescale 1ns/1ns
`default_nettype none
module indsp_core_bench;
  import indsp_pkg::*;
  logic       ref_clk, rst_b, extra_enable_n, bank_select;
  logic       rf_in = 1'b0;
  logic       ref_in = 1'b0;
  logic       sclk, sdata, serial_write, extra_write;
  logic       pump_up_n, pump_down_n, lock_filter, lock_o, lock_oe, divider_out;
  int         num_errors, samples_checked, tcnt, rf_cnt, ref_cnt, up_low, dn_low;
  int         tm[5] = '{1, 5, 1, 1, 2};
  int         ta[5] = '{0, 0, 0, 2, 3};
  int         tb[5] = '{1, 1, 0, 0, 0};
  int         te[5] = '{2, 6, 20, 22, 33};
  logic [5:0] rr[3] = '{6'h00, 6'h03, 6'h3f};

  indsp_ctrl_model i_ctrl (.ref_clk(ref_clk), .sclk(sclk), .sdata(sdata),
    .serial_write(serial_write), .extra_write(extra_write));
  indsp_core i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .rf_in(rf_in), .ref_in(ref_in),
    .sclk(sclk), .sdata(sdata), .serial_write(serial_write), .extra_write(extra_write),
    .extra_enable_n(extra_enable_n), .bank_select(bank_select), .pump_up_n(pump_up_n),
    .pump_down_n(pump_down_n), .lock_filter(lock_filter), .lock_indicator_o(lock_o),
    .lock_indicator_oe(lock_oe), .divider_out(divider_out));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // RF input toggles every 4 clocks, reference every 5; rising edges are counted
  always @(posedge ref_clk) begin
    tcnt <= tcnt + 1;
    if (tcnt % 4 == 0) rf_in <= ~rf_in;
    if (tcnt % 4 == 0 && !rf_in) rf_cnt <= rf_cnt + 1;
    if (tcnt % 5 == 0) ref_in <= ~ref_in;
    if (tcnt % 5 == 0 && !ref_in) ref_cnt <= ref_cnt + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [PRIM_W-1:0] set_word(input logic [5:0] r, input logic [8:0] m,
                                                 input logic b, input logic [3:0] a);
    return {r[5:4], m[8:7], b, m[6:0], r[3:0], a};
  endfunction : set_word
  task automatic fail(input string m);
    num_errors++;
    $display("[ERR] %0t %s", $time, m);
  endtask : fail
  task automatic chk_n(input int got, input int exp);
    samples_checked++;
    if (got != exp) fail($sformatf("count %0d, expected %0d", got, exp));
  endtask : chk_n
  task automatic chk_b(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) fail("output level mismatch");
  endtask : chk_b
  task automatic conclude;
    $display("checks %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  task automatic wait_rise;
    int k;
    k = 0;
    while (divider_out !== 1'b0 && k < 3000) begin
      @(posedge ref_clk);
      k++;
    end
    while (divider_out !== 1'b1 && k < 3000) begin
      @(posedge ref_clk);
      k++;
    end
    if (k >= 3000) begin
      fail("divider output stuck");
      conclude();
    end
  endtask : wait_rise
  // First interval is skipped: without counter load, new settings only land at a terminal count
  task automatic ratio(input logic use_ref, input int exp);
    int c0;
    wait_rise();
    wait_rise();
    c0 = use_ref ? ref_cnt : rf_cnt;
    wait_rise();
    chk_n((use_ref ? ref_cnt : rf_cnt) - c0, exp);
  endtask : ratio
  task automatic watch(input int n);
    up_low = 0;
    dn_low = 0;
    repeat (n) begin
      @(posedge ref_clk);
      up_low += int'(pump_up_n === 1'b0);
      dn_low += int'(pump_down_n === 1'b0);
      chk_b(lock_filter, ~(pump_up_n & pump_down_n));
      chk_b(lock_oe, ~(pump_up_n & pump_down_n));
      chk_b(lock_o, 1'b0);
    end
  endtask : watch

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b          = 1'b0;
    extra_enable_n = 1'b1;
    bank_select    = 1'b1;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    i_ctrl.write_extra(8'h01 << ENH_FP_OUT);
    extra_enable_n <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      i_ctrl.write_setting(set_word(6'h00, tm[i][8:0], tb[i][0], ta[i][3:0]), 1'b1);
      ratio(1'b0, te[i]);
    end
    i_ctrl.write_extra(8'h01 << ENH_FC_OUT);
    foreach (rr[j]) begin
      i_ctrl.write_setting(set_word(rr[j], 9'h001, 1'b1, 4'h0), 1'b1);
      ratio(1'b1, int'(rr[j]) + 1);
    end
    i_ctrl.write_extra(8'h01 << ENH_FP_OUT);
    i_ctrl.write_setting(set_word(6'h00, 9'h001, 1'b1, 4'h0), 1'b1);
    i_ctrl.write_setting(set_word(6'h00, 9'h003, 1'b1, 4'h0), 1'b0);
    bank_select <= 1'b0;
    ratio(1'b0, 2);
    bank_select <= 1'b1;
    ratio(1'b0, 4);
    i_ctrl.write_extra((8'h01 << ENH_MODULUS_SELECT_OUT) | (8'h01 << ENH_CNT_LOAD));
    i_ctrl.write_setting(set_word(6'h00, 9'h002, 1'b0, 4'h1), 1'b1);
    ratio(1'b0, 31);
    i_ctrl.write_extra(8'h01 << ENH_PWR_DN);
    i_ctrl.write_setting(set_word(6'h03, 9'h001, 1'b1, 4'h0), 1'b1);
    watch(400);
    chk_n(up_low + dn_low, 0);
    extra_enable_n <= 1'b1;
    watch(400);
    chk_b(dn_low > up_low, 1'b1);
    conclude();
  end
endmodule : indsp_core_bench
`default_nettype wire
